// ### src/abd_pkg.sv
// package for the auto-baud measurement block and its sync-byte sender
// assumes a single 50 MHz clock shared by both ends
package abd_pkg;
  // ----------------------------------------
  // software register map (controller side)
  // ----------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_DIV_LOW = 4'h3;
  localparam logic [3:0] ADDR_DIV_HIGH = 4'h4;
  localparam logic [3:0] ADDR_RX_DATA = 4'h5;
  localparam logic [3:0] ADDR_TX_DATA = 4'h6;
  localparam logic [3:0] ADDR_BAUD_CTRL = 4'h7;
  // control register bit positions
  localparam int CTL_AUTO_BAUD = 0;
  localparam int CTL_WAKE_UP = 1;
  localparam int CTL_WIDE_DIV = 2;
  localparam int CTL_HIGH_SPEED = 3;
  localparam int CTL_ASYNC = 4;
  // baud control register: overflow flag position
  localparam int BCTL_OVERFLOW = 7;
  // status / mask bit positions
  localparam int ST_DONE = 0;
  localparam int ST_OVERFLOW = 1;
  localparam int ST_TX_REFUSED = 2;
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h10;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
  // counter clock prescale figures
  localparam int PRE_SLOW = 512;
  localparam int PRE_MID = 128;
  localparam int PRE_FAST = 32;
  localparam int MEASURE_SLOWDOWN = 8;
  // sync byte and edge count
  localparam logic [7:0] SYNC_BYTE = 8'h55;
  localparam logic [2:0] LAST_RISE = 3'h5;
  // sender timing
  localparam int CLK_MHZ = 50;
  localparam int BIT_TIME_US = 104;
  localparam int BIT_CYCLES = BIT_TIME_US * CLK_MHZ;
  localparam logic [15:0] BIT_CYCLES_W = 16'(BIT_CYCLES);
  localparam int BREAK_BITS = 13;

  // counter clock divide for the selected mode, stretched for measuring
  function automatic logic [12:0] measure_div(input logic wide, input logic fast);
    logic [12:0] base;
    base = 13'(PRE_MID);
    if (!wide && !fast)
      base = 13'(PRE_SLOW);
    else if (wide && fast)
      base = 13'(PRE_FAST);
    measure_div = 13'(base * MEASURE_SLOWDOWN);
  endfunction
endpackage

// ### src/abd_link_if.sv
// serial line joining the sync sender and the measuring receiver
// assumes both ends run on the same clock
interface abd_link_if;
  logic line; // serial level, idle high
  modport sender (output line);
  modport receiver (input line);
endinterface

// ### src/abd_sync_sender.sv
// remote transmitter: sends an optional break then the sync byte 55h
// assumes one 50 MHz clock; bit time fixed by package constant
module abd_sync_sender
  import abd_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_rst, // synchronous reset, high
  input wire logic i_send, // pulse: start a sync frame
  input wire logic i_with_break, // precede the byte with a break
  output logic o_busy, // frame in progress
  abd_link_if.sender link // serial line out
);
  typedef enum {S_IDLE, S_BREAK, S_FRAME} send_state_t;
  send_state_t state;
  logic [15:0] bit_cnt;
  logic [3:0] bit_idx;
  logic [9:0] frame;
  wire bit_end = (bit_cnt == BIT_CYCLES_W - 16'h0001);

  // -------------------------------------------
  // framing: start, 8 data lsb first, stop
  // -------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= S_IDLE;
      bit_cnt <= 16'h0000;
      bit_idx <= 4'h0;
      frame <= 10'h3ff;
      link.line <= 1'b1;
      o_busy <= 1'b0;
    end
    else
    begin
      bit_cnt <= (state == S_IDLE || bit_end) ? 16'h0000 : bit_cnt + 16'h0001;
      case (state)
        S_IDLE:
        begin
          bit_idx <= 4'h0;
          if (i_send)
          begin
            frame <= {1'b1, SYNC_BYTE, 1'b0};
            o_busy <= 1'b1;
            link.line <= 1'b0;
            state <= i_with_break ? S_BREAK : S_FRAME;
          end
        end
        S_BREAK:
          if (bit_end)
          begin
            if (bit_idx == 4'(BREAK_BITS - 1))
            begin
              bit_idx <= 4'h0;
              link.line <= 1'b0; // start bit follows the high bit
              state <= S_FRAME;
            end
            else
            begin
              bit_idx <= bit_idx + 4'h1;
              link.line <= (bit_idx == 4'(BREAK_BITS - 2)); // break then one high bit
            end
          end
        S_FRAME:
          if (bit_end)
          begin
            if (bit_idx == 4'h9)
            begin
              state <= S_IDLE;
              o_busy <= 1'b0;
              link.line <= 1'b1;
            end
            else
            begin
              bit_idx <= bit_idx + 4'h1;
              link.line <= frame[bit_idx + 4'h1];
            end
          end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

// ### src/abd_measure.sv
// auto-baud measuring receiver with software register port
// assumes inputs synchronous to i_clk; line from abd_link_if
//
// Overview of operation
// - measure only in async mode, wake-up set or clear
// - enable clears counter, then awaits start bit
// - sender must send 55h sync byte
// - low and high bit times both timed
// - counting starts at first rising edge
// - fifth rising edge leaves divisor in registers
// - fifth rising edge clears auto-baud enable
// - counter wrap sets overflow flag, software writable
// - measuring continues after wrap, enable stays
// - counter clocked at one eighth rate
// - 16-bit and high-speed bits pick prescale
// - 8-bit modes: high byte 00h means no carry
// - serial state machine held idle while measuring
// - fifth edge sets receive flag; data read clears
// - wake-up plus enable measures byte after break
// - transmit data writes ignored while enabled
// - software must not enable during transmission
// - software should select wide divisor
//
// The address map and the address-and-strobe port are this design's own decisions.
module abd_measure
  import abd_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_rst, // synchronous reset, high
  input wire logic [3:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, cycle after strobe
  output logic o_irq, // level interrupt
  output logic o_measuring, // measurement in progress
  output logic o_rx_flag, // receive interrupt flag
  output logic [15:0] o_divisor, // active baud divisor
  abd_link_if.receiver link // serial line in
);
  typedef enum {M_IDLE, M_BREAK, M_START, M_FIRST, M_COUNT} meas_state_t;
  meas_state_t state;
  logic [7:0] control;
  logic [2:0] status;
  logic [2:0] mask;
  logic [15:0] divisor;
  logic [7:0] rx_data;
  logic [7:0] tx_data;
  logic overflow_flag;
  logic line_q;
  logic [12:0] pre_cnt;
  logic [2:0] rises;

  // -------------------------------------------
  // decode and events
  // -------------------------------------------
  wire enable = control[CTL_AUTO_BAUD];
  wire wake = control[CTL_WAKE_UP];
  wire async_mode = control[CTL_ASYNC];
  wire rise = link.line && !line_q;
  wire fall = !link.line && line_q;
  wire [12:0] div_sel = measure_div(control[CTL_WIDE_DIV], control[CTL_HIGH_SPEED]);
  wire tick = (pre_cnt == div_sel - 13'h0001);
  wire counting = (state == M_COUNT) || (state == M_FIRST && rise);
  wire wrap = counting && tick && (divisor == 16'hffff);
  wire wide_wrap = control[CTL_WIDE_DIV] ? wrap : (counting && tick && divisor[7:0] == 8'hff);
  wire done = (state == M_COUNT) && rise && (rises == LAST_RISE - 3'h1);
  wire wr_ctl = i_wr && i_addr == ADDR_CONTROL;
  wire wr_st = i_wr && i_addr == ADDR_STATUS;
  wire wr_bctl = i_wr && i_addr == ADDR_BAUD_CTRL;
  wire rd_rx = i_rd && i_addr == ADDR_RX_DATA;
  wire tx_wr = i_wr && i_addr == ADDR_TX_DATA;
  wire tx_refused = tx_wr && enable;
  wire [2:0] events = {tx_refused, wide_wrap, done};
  // divisor step: in 8-bit modes carry lands in high byte for software check
  wire [15:0] next_divisor = divisor + 16'h0001;
  // value the divisor holds after this edge, for loading the active copy
  wire [15:0] final_divisor = (counting && tick) ? next_divisor : divisor;
  wire [7:0] next_rdata =
    (i_addr == ADDR_CONTROL) ? control :
    (i_addr == ADDR_STATUS) ? {5'h00, status} :
    (i_addr == ADDR_MASK) ? {5'h00, mask} :
    (i_addr == ADDR_DIV_LOW) ? divisor[7:0] :
    (i_addr == ADDR_DIV_HIGH) ? divisor[15:8] :
    (i_addr == ADDR_RX_DATA) ? rx_data :
    (i_addr == ADDR_TX_DATA) ? tx_data :
    (i_addr == ADDR_BAUD_CTRL) ? {overflow_flag, 7'h00} : 8'h00;

  // -------------------------------------------
  // measuring state machine
  // -------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= M_IDLE;
      line_q <= 1'b1;
      pre_cnt <= 13'h0000;
      rises <= 3'h0;
    end
    else
    begin
      line_q <= link.line;
      pre_cnt <= (!counting || tick) ? 13'h0000 : pre_cnt + 13'h0001;
      case (state)
        M_IDLE:
          if (enable && async_mode)
            state <= wake ? M_BREAK : M_START;
        M_BREAK:
          if (rise) // break over, next byte measured
            state <= M_START;
        M_START:
          if (fall) // start bit seen
            state <= M_FIRST;
        M_FIRST:
          if (rise)
          begin
            rises <= 3'h1;
            state <= M_COUNT;
          end
        M_COUNT:
          if (rise)
          begin
            rises <= rises + 3'h1; // spans low and high bits
            if (done)
              state <= M_IDLE;
          end
        default: state <= M_IDLE;
      endcase
      if (!enable || !async_mode)
        state <= M_IDLE;
    end
  end

  // -------------------------------------------
  // divisor counter and control
  // -------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      divisor <= DIVISOR_RESET;
      control <= CONTROL_RESET;
    end
    else
    begin
      if (wr_ctl)
        control <= i_wdata;
      if (i_wr && i_addr == ADDR_DIV_LOW)
        divisor[7:0] <= i_wdata;
      if (i_wr && i_addr == ADDR_DIV_HIGH)
        divisor[15:8] <= i_wdata;
      if (wr_ctl && i_wdata[CTL_AUTO_BAUD] && !enable)
        divisor <= 16'h0000;
      else if (counting && tick)
        divisor <= next_divisor; // keeps counting past wrap
      if (done)
        control[CTL_AUTO_BAUD] <= 1'b0;
    end
  end

  // -------------------------------------------
  // flags, data registers and interrupt
  // -------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      status <= 3'h0;
      mask <= 3'h0;
      overflow_flag <= 1'b0;
      o_rx_flag <= 1'b0;
      rx_data <= 8'h00;
      tx_data <= 8'h00;
      o_rdata <= 8'h00;
      o_irq <= 1'b0;
      o_measuring <= 1'b0;
      o_divisor <= DIVISOR_RESET;
    end
    else
    begin
      o_rdata <= i_rd ? next_rdata : 8'h00;
      status <= (status & ~(wr_st ? i_wdata[2:0] : 3'h0)) | events; // set wins
      if (i_wr && i_addr == ADDR_MASK)
        mask <= i_wdata[2:0];
      if (wr_bctl)
        overflow_flag <= i_wdata[BCTL_OVERFLOW];
      if (wrap)
        overflow_flag <= 1'b1;
      if (rd_rx)
        o_rx_flag <= 1'b0;
      if (done)
      begin
        o_rx_flag <= 1'b1;
        rx_data <= SYNC_BYTE; // value to be discarded
      end
      if (tx_wr && !enable)
        tx_data <= i_wdata;
      o_irq <= |(((status & ~(wr_st ? i_wdata[2:0] : 3'h0)) | events) & mask);
      o_measuring <= enable && async_mode; // serial engine held idle
      if (done)
        o_divisor <= final_divisor;
      else if (!enable)
        o_divisor <= divisor;
    end
  end
endmodule

// ### test/abd_measure_asserts.sv
// concurrent checks on the serial line and the measuring receiver
// assumes one clock domain; instantiated beside the link in the bench
module abd_measure_asserts
  import abd_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_rst, // synchronous reset
  input wire logic line, // serial line
  input wire logic [3:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [7:0] o_rdata, // read data
  input wire logic o_irq, // interrupt
  input wire logic o_measuring, // measuring
  input wire logic o_rx_flag, // receive flag
  input wire logic [15:0] o_divisor, // active divisor
  input wire logic o_busy // sender busy
);
  // ----------------------------------------
  // helpers and checks
  // ----------------------------------------
  wire logic ctl_go;
  wire logic rx_read;
  assign ctl_go = i_wr && i_addr == ADDR_CONTROL && i_wdata[CTL_AUTO_BAUD] && i_wdata[CTL_ASYNC];
  assign rx_read = i_rd && i_addr == ADDR_RX_DATA;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  measure_start_a: assert property ($rose(o_measuring) |-> $past(ctl_go) || $past(ctl_go, 2))
    else $error("measuring began without an async enable write");
  measure_end_a: assert property ($fell(o_measuring) |-> o_rx_flag || $past(i_wr) || $past(i_wr, 2))
    else $error("measuring ended without completion");
  flag_at_stop_a: assert property ($rose(o_rx_flag) |-> line ##[0:1] !o_measuring)
    else $error("receive flag not at stop bit");
  flag_sticky_a: assert property (o_rx_flag && !rx_read |=> o_rx_flag)
    else $error("receive flag dropped without data read");
  flag_clear_a: assert property (o_rx_flag && rx_read |=> ##[0:1] !o_rx_flag)
    else $error("receive flag not cleared by data read");
  divisor_hold_a: assert property (o_measuring ##1 (o_measuring && !$rose(o_rx_flag)) |-> $stable(o_divisor))
    else $error("active divisor moved during measuring");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  idle_high_a: assert property (!o_busy |-> line)
    else $error("line not idle high");
  start_low_a: assert property ($rose(o_busy) |-> !line)
    else $error("frame does not open with start bit");
  cover property ($rose(o_measuring));
  cover property ($rose(o_rx_flag));
  cover property ($rose(o_irq));
endmodule

// ### test/test_uart_auto_baud_detect.sv
// bench: sync sender drives the measuring receiver over the link
// assumes 50 MHz clock; one full sync frame at the fast prescale
module test_uart_auto_baud_detect;
  import abd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_send = 1'b0;
  logic i_with_break = 1'b0;
  logic [7:0] o_rdata;
  logic o_irq, o_measuring, o_rx_flag, o_busy;
  logic [15:0] o_divisor;
  int bad_count = 0;
  int n_tests = 0;
  abd_link_if u_abd_link_if();
  abd_sync_sender u_abd_sync_sender (.i_clk(i_clk), .i_rst(i_rst), .i_send(i_send),
    .i_with_break(i_with_break), .o_busy(o_busy), .link(u_abd_link_if));
  abd_measure u_abd_measure (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_measuring(o_measuring),
    .o_rx_flag(o_rx_flag), .o_divisor(o_divisor), .link(u_abd_link_if));
  abd_measure_asserts u_abd_measure_asserts (.i_clk(i_clk), .i_rst(i_rst), .line(u_abd_link_if.line),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_measuring(o_measuring), .o_rx_flag(o_rx_flag), .o_divisor(o_divisor), .o_busy(o_busy));
  // ----------------------------------------
  // clock and shared tasks
  // ----------------------------------------
  initial
  begin
    forever #10 i_clk = ~i_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // control reset value, unmapped read, no measuring outside async mode
  task automatic t_idle();
    logic [7:0] d;
    rd(ADDR_CONTROL, d); check(16'(d), 16'(CONTROL_RESET));
    rd(4'hf, d); check(16'(d), 16'h0000);
    wr(ADDR_CONTROL, 8'h0d);
    @(posedge i_clk);
    #1 check(16'(o_measuring), 16'h0000);
    wr(ADDR_CONTROL, 8'h10);
    wr(ADDR_TX_DATA, 8'h5a);
    rd(ADDR_TX_DATA, d); check(16'(d), 16'h005a);
    wr(ADDR_BAUD_CTRL, 8'h80);
    rd(ADDR_BAUD_CTRL, d); check(16'(d[BCTL_OVERFLOW]), 16'h0001);
    wr(ADDR_BAUD_CTRL, 8'h00);
  endtask
  // full sync frame at fast prescale, then flags, mask and divisor
  task automatic t_measure();
    logic [7:0] lo, hi, d;
    int exp;
    exp = 8 * BIT_CYCLES / (PRE_FAST * MEASURE_SLOWDOWN);
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_CONTROL, 8'h1d);
    @(posedge i_clk);
    #1 check(16'(o_measuring), 16'h0001);
    wr(ADDR_TX_DATA, 8'ha5);
    rd(ADDR_STATUS, d); check(16'(d[ST_TX_REFUSED]), 16'h0001);
    rd(ADDR_TX_DATA, d); check(16'(d), 16'h005a);
    wr(ADDR_STATUS, 8'h04);
    @(posedge i_clk);
    i_send <= 1'b1;
    @(posedge i_clk);
    i_send <= 1'b0;
    for (int n = 0; n < 60000 && o_rx_flag !== 1'b1; n++) @(posedge i_clk);
    repeat (2) @(posedge i_clk);
    check(16'(o_rx_flag), 16'h0001);
    check(16'(o_irq), 16'h0001);
    rd(ADDR_CONTROL, d); check(16'(d[CTL_AUTO_BAUD]), 16'h0000);
    rd(ADDR_DIV_LOW, lo);
    rd(ADDR_DIV_HIGH, hi);
    check(16'({hi, lo} >= 16'(exp - 1) && {hi, lo} <= 16'(exp + 1)), 16'h0001);
    check(o_divisor, {hi, lo});
    rd(ADDR_BAUD_CTRL, d); check(16'(d[BCTL_OVERFLOW]), 16'h0000);
    wr(ADDR_MASK, 8'h00);
    @(posedge i_clk);
    #1 check(16'(o_irq), 16'h0000);
    rd(ADDR_RX_DATA, d); check(16'(d), 16'(SYNC_BYTE));
    #1 check(16'(o_rx_flag), 16'h0000);
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_STATUS, 8'h01);
    #1 check(16'(o_irq), 16'h0000);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    t_idle();
    t_measure();
    print_verdict();
  end
  initial
  begin
    repeat (80000) @(posedge i_clk);
    bad_count++;
    print_verdict();
  end
endmodule
